// ### logic/dma_flags_params.svh
// constants for the dma channel event flag and source address block
`ifndef DMA_FLAGS_PARAMS_SVH
`define DMA_FLAGS_PARAMS_SVH

//------------------------------------------------------------
// register byte offsets
//------------------------------------------------------------
`define OFS_EVENT_FLAGS   12'h000
`define OFS_SRC_START     12'h010
`define OFS_DEST_SIZE     12'h020
`define OFS_SOURCE_SIZE   12'h030
`define OFS_CELL_SIZE     12'h040
`define OFS_CHAN_CTRL     12'h050
`define OFS_DEST_POINTER  12'h060
`define OFS_IRQ_MASK      12'h070

//------------------------------------------------------------
// event flag bit positions
//------------------------------------------------------------
`define BIT_ADDR_ERR      0
`define BIT_XFER_ABORT    1
`define BIT_CELL_DONE     2
`define BIT_BLOCK_DONE    3
`define BIT_DEST_HALF     4
`define BIT_DEST_DONE     5
`define NUM_FLAGS         6

//------------------------------------------------------------
// control register fields
//------------------------------------------------------------
`define BIT_CTRL_ENABLE   0
`define BIT_CTRL_ABORT_EN 1
`define CTRL_SEL_LSB      8
`define CTRL_SEL_MSB      10

//------------------------------------------------------------
// reset values and bus answers
//------------------------------------------------------------
`define RST_SRC_START     32'h0000_0000
`define RST_SIZE          16'h0000
`define RST_CTRL          32'h0000_0000
`define RST_MASK          6'h00
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

`endif

// ### logic/dma_flags_pkg.sv
// types shared by the dma channel event flag block
package dma_flags_pkg;

  typedef enum logic [1:0] {
    CH_IDLE = 2'b00,
    CH_RUN  = 2'b01,
    CH_STOP = 2'b11
  } chan_state_e;

  // one-cycle pulses from the channel datapath, same clock
  typedef struct packed {
    logic       byte_moved;
    logic       pattern_match;
    logic       src_addr_err;
    logic       dst_addr_err;
  } chan_evt_s;

  typedef struct packed {
    logic [31:0] source_addr;
    logic [15:0] dest_pointer;
    logic        busy;
  } chan_pos_s;

endpackage : dma_flags_pkg

// ### logic/event_flag_bank.sv
// sticky event flags, set has priority over clear
`timescale 1ns/1ns
`include "dma_flags_params.svh"

module event_flag_bank (
  input  wire logic                    clk_sys,
  input  wire logic                    reset_n,
  input  wire logic [`NUM_FLAGS-1:0]   set_pulse,
  input  wire logic [`NUM_FLAGS-1:0]   clr_pulse,
  output logic      [`NUM_FLAGS-1:0]   flags
);
  import dma_flags_pkg::*;

  genvar i;
  generate
    for (i = 0; i < `NUM_FLAGS; i = i + 1) begin : g_flag
      logic flag_reg;
      always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
          flag_reg <= 1'b0;
        end else if (set_pulse[i]) begin
          flag_reg <= 1'b1; // see R9
        end else if (clr_pulse[i]) begin
          flag_reg <= 1'b0; // see R9
        end
      end
      assign flags[i] = flag_reg;
    end
  endgenerate

endmodule : event_flag_bank

// ### logic/dma_channel_flags.sv
// dma channel with event flags, source start address and axi4-lite registers
// How it works
// R1: the destination half-full flag, bit 4, rises when the destination pointer reaches half the destination size.
// R2: the block-complete flag, bit 3, rises when the larger of source and destination size has moved, or on pattern match.
// R3: the cell-complete flag, bit 2, rises each time a cell-size count of bytes has moved.
// R4: when the selected abort interrupt is seen, the transfer stops and the abort flag, bit 1, rises.
// R5: the address-error flag, bit 0, rises when the source or destination address is found invalid.
// R6: the source start address register is 32 bits, fully read/write, zero after reset.
// R7: software loads the source start address with a physical address, never a virtual one.
// R8: the destination-done flag, bit 5, rises when the destination pointer equals the destination size.
// R9: each flag stays set until software clears it and reads as zero otherwise.
//
// The register offsets and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ns
`include "dma_flags_params.svh"

module dma_channel_flags (
  input  wire logic                  clk_sys,
  input  wire logic                  reset_n,
  // axi4-lite slave
  input  wire logic [11:0]           s_axi_awaddr,
  input  wire logic [2:0]            s_axi_awprot,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [11:0]           s_axi_araddr,
  input  wire logic [2:0]            s_axi_arprot,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // channel side
  input  wire dma_flags_pkg::chan_evt_s chan_evt,
  input  wire logic [7:0]            irq_lines,
  output dma_flags_pkg::chan_pos_s   chan_pos,
  output logic                       irq
);
  import dma_flags_pkg::*;

  //------------------------------------------------------------
  // helpers
  //------------------------------------------------------------
  function automatic logic [31:0] merge_strb(input logic [31:0] old_val,
                                             input logic [31:0] new_val,
                                             input logic [3:0]  strb);
    logic [31:0] res;
    res = old_val;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = new_val[b*8 +: 8];
      end
    end
    return res;
  endfunction : merge_strb

  function automatic logic is_mapped(input logic [11:0] addr);
    unique case (addr)
      `OFS_EVENT_FLAGS, `OFS_SRC_START, `OFS_DEST_SIZE, `OFS_SOURCE_SIZE,
      `OFS_CELL_SIZE, `OFS_CHAN_CTRL, `OFS_DEST_POINTER, `OFS_IRQ_MASK: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : is_mapped

  //------------------------------------------------------------
  // registers and state
  //------------------------------------------------------------
  logic [31:0]            src_start_reg;
  logic [15:0]            dest_size_reg;
  logic [15:0]            source_size_reg;
  logic [15:0]            cell_size_reg;
  logic [31:0]            ctrl_reg;
  logic [`NUM_FLAGS-1:0]  mask_reg;
  logic [15:0]            dest_ptr_reg;
  logic [15:0]            src_ptr_reg;
  logic [15:0]            cell_cnt_reg;
  logic [16:0]            total_cnt_reg;
  chan_state_e            state_reg;

  logic                   aw_held_reg;
  logic                   w_held_reg;
  logic [11:0]            waddr_reg;
  logic [31:0]            wdata_reg;
  logic [3:0]             wstrb_reg;
  logic                   awready_reg;
  logic                   wready_reg;
  logic                   bvalid_reg;
  logic [1:0]             bresp_reg;
  logic                   arready_reg;
  logic                   rvalid_reg;
  logic [31:0]            rdata_reg;
  logic [1:0]             rresp_reg;
  logic                   irq_reg;
  chan_pos_s              pos_reg;

  logic [`NUM_FLAGS-1:0]  flags;
  logic [`NUM_FLAGS-1:0]  flag_set;
  logic [`NUM_FLAGS-1:0]  flag_clr;
  logic                   wr_fire;
  logic                   rd_fire;
  logic                   step;
  logic [15:0]            dest_ptr_inc;
  logic [15:0]            src_ptr_inc;
  logic [15:0]            cell_cnt_inc;
  logic [16:0]            total_cnt_inc;
  logic [16:0]            block_len;
  logic                   hit_half;
  logic                   hit_dest_done;
  logic                   hit_src_wrap;
  logic                   hit_cell;
  logic                   hit_block;
  logic                   hit_abort;
  logic                   hit_addr_err;
  logic                   chan_end;
  logic [2:0]             abort_sel;

  //------------------------------------------------------------
  // axi4-lite write channel
  //------------------------------------------------------------
  // address and data are taken in either order; the write lands once both are held
  assign wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      awready_reg <= 1'b1;
      wready_reg  <= 1'b1;
      waddr_reg   <= 12'h000;
      wdata_reg   <= 32'h0000_0000;
      wstrb_reg   <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid && awready_reg) begin
        aw_held_reg <= 1'b1;
        awready_reg <= 1'b0;
        waddr_reg   <= s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_reg) begin
        w_held_reg <= 1'b1;
        wready_reg <= 1'b0;
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held_reg <= 1'b0;
        w_held_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        // read-only registers accept the write silently, unmapped ones answer slverr
        bresp_reg   <= is_mapped(waddr_reg) ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (bvalid_reg && s_axi_bready) begin
        bvalid_reg  <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg  <= 1'b1;
      end
    end
  end

  //------------------------------------------------------------
  // software-written registers
  //------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      src_start_reg   <= `RST_SRC_START; // see R6
      dest_size_reg   <= `RST_SIZE;
      source_size_reg <= `RST_SIZE;
      cell_size_reg   <= `RST_SIZE;
      mask_reg        <= `RST_MASK;
    end else if (wr_fire) begin
      unique case (waddr_reg)
        `OFS_SRC_START:   src_start_reg <= merge_strb(src_start_reg, wdata_reg, wstrb_reg); // see R6
        `OFS_DEST_SIZE:   dest_size_reg <= 16'(merge_strb({16'h0000, dest_size_reg}, wdata_reg, wstrb_reg));
        `OFS_SOURCE_SIZE: source_size_reg <= 16'(merge_strb({16'h0000, source_size_reg}, wdata_reg, wstrb_reg));
        `OFS_CELL_SIZE:   cell_size_reg <= 16'(merge_strb({16'h0000, cell_size_reg}, wdata_reg, wstrb_reg));
        `OFS_IRQ_MASK:    mask_reg <= `NUM_FLAGS'(merge_strb({26'h0, mask_reg}, wdata_reg, wstrb_reg));
        default: begin
        end
      endcase
    end
  end

  // hardware drops the enable when the channel ends; a software write in the same cycle wins
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      ctrl_reg <= `RST_CTRL;
    end else if (wr_fire && waddr_reg == `OFS_CHAN_CTRL) begin
      ctrl_reg <= merge_strb(ctrl_reg, wdata_reg, wstrb_reg) & 32'h0000_0703;
    end else if (chan_end) begin
      ctrl_reg[`BIT_CTRL_ENABLE] <= 1'b0;
    end
  end

  //------------------------------------------------------------
  // axi4-lite read channel
  //------------------------------------------------------------
  assign rd_fire = s_axi_arvalid && arready_reg;

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0000_0000;
      rresp_reg   <= `RESP_OKAY;
    end else begin
      if (rd_fire) begin
        arready_reg <= 1'b0;
        rvalid_reg  <= 1'b1;
        rresp_reg   <= is_mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
        unique case (s_axi_araddr)
          `OFS_EVENT_FLAGS:  rdata_reg <= {26'h0, flags}; // see R9
          `OFS_SRC_START:    rdata_reg <= src_start_reg;
          `OFS_DEST_SIZE:    rdata_reg <= {16'h0000, dest_size_reg};
          `OFS_SOURCE_SIZE:  rdata_reg <= {16'h0000, source_size_reg};
          `OFS_CELL_SIZE:    rdata_reg <= {16'h0000, cell_size_reg};
          `OFS_CHAN_CTRL:    rdata_reg <= ctrl_reg;
          `OFS_DEST_POINTER: rdata_reg <= {16'h0000, dest_ptr_reg};
          `OFS_IRQ_MASK:     rdata_reg <= {26'h0, mask_reg};
          default:           rdata_reg <= 32'h0000_0000;
        endcase
      end
      if (rvalid_reg && s_axi_rready) begin
        rvalid_reg  <= 1'b0;
        arready_reg <= 1'b1;
      end
    end
  end

  //------------------------------------------------------------
  // transfer progress and event detection
  //------------------------------------------------------------
  assign abort_sel     = ctrl_reg[`CTRL_SEL_MSB:`CTRL_SEL_LSB];
  assign step          = (state_reg == CH_RUN) && chan_evt.byte_moved && !hit_abort;
  assign dest_ptr_inc  = dest_ptr_reg + 16'h0001;
  assign src_ptr_inc   = src_ptr_reg + 16'h0001;
  assign cell_cnt_inc  = cell_cnt_reg + 16'h0001;
  assign total_cnt_inc = total_cnt_reg + 17'h0_0001;
  // the block is as long as the larger of the two sizes
  assign block_len     = {1'b0, (source_size_reg > dest_size_reg) ? source_size_reg : dest_size_reg};

  assign hit_half      = step && (dest_ptr_inc == {1'b0, dest_size_reg[15:1]}); // see R1
  assign hit_dest_done = step && (dest_ptr_inc == dest_size_reg); // see R8
  assign hit_src_wrap  = step && (src_ptr_inc == source_size_reg);
  assign hit_cell      = step && (cell_cnt_inc == cell_size_reg); // see R3
  assign hit_block     = (step && (total_cnt_inc == block_len))
                      || ((state_reg == CH_RUN) && chan_evt.pattern_match); // see R2
  // an irq line is another peripheral's flop on this clock, so no synchroniser
  assign hit_abort     = (state_reg == CH_RUN) && ctrl_reg[`BIT_CTRL_ABORT_EN] && irq_lines[abort_sel]; // see R4
  assign hit_addr_err  = (state_reg == CH_RUN) && (chan_evt.src_addr_err || chan_evt.dst_addr_err); // see R5
  // an address error also stops the channel rather than move to a bad address
  assign chan_end      = hit_block || hit_abort || hit_addr_err;

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      state_reg <= CH_IDLE;
    end else begin
      unique case (state_reg)
        CH_IDLE: if (ctrl_reg[`BIT_CTRL_ENABLE]) state_reg <= CH_RUN;
        CH_RUN:  if (chan_end) state_reg <= CH_STOP; // see R4
        CH_STOP: state_reg <= CH_IDLE;
        default: state_reg <= CH_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      dest_ptr_reg  <= 16'h0000;
      src_ptr_reg   <= 16'h0000;
      cell_cnt_reg  <= 16'h0000;
      total_cnt_reg <= 17'h0_0000;
    end else if (state_reg == CH_IDLE) begin
      dest_ptr_reg  <= 16'h0000;
      src_ptr_reg   <= 16'h0000;
      cell_cnt_reg  <= 16'h0000;
      total_cnt_reg <= 17'h0_0000;
    end else if (step) begin
      dest_ptr_reg  <= hit_dest_done ? 16'h0000 : dest_ptr_inc;
      src_ptr_reg   <= hit_src_wrap ? 16'h0000 : src_ptr_inc;
      cell_cnt_reg  <= hit_cell ? 16'h0000 : cell_cnt_inc; // see R3
      total_cnt_reg <= total_cnt_inc;
    end
  end

  //------------------------------------------------------------
  // event flags and interrupt
  //------------------------------------------------------------
  always_comb begin
    flag_set                  = '0;
    flag_set[`BIT_ADDR_ERR]   = hit_addr_err;
    flag_set[`BIT_XFER_ABORT] = hit_abort;
    flag_set[`BIT_CELL_DONE]  = hit_cell;
    flag_set[`BIT_BLOCK_DONE] = hit_block;
    flag_set[`BIT_DEST_HALF]  = hit_half;
    flag_set[`BIT_DEST_DONE]  = hit_dest_done;
  end

  // a read of the flag register clears exactly what it returned
  assign flag_clr = (rd_fire && s_axi_araddr == `OFS_EVENT_FLAGS) ? flags : '0; // see R9

  event_flag_bank u_flags (
    .clk_sys   (clk_sys),
    .reset_n   (reset_n),
    .set_pulse (flag_set),
    .clr_pulse (flag_clr),
    .flags     (flags)
  );

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(flags & mask_reg);
    end
  end

  // the address is used as given; translation is software's job
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      pos_reg <= '0;
    end else begin
      pos_reg.source_addr  <= src_start_reg + {16'h0000, src_ptr_reg}; // see R7
      pos_reg.dest_pointer <= dest_ptr_reg;
      pos_reg.busy         <= (state_reg == CH_RUN);
    end
  end

  //------------------------------------------------------------
  // outputs
  //------------------------------------------------------------
  assign s_axi_awready = awready_reg;
  assign s_axi_wready  = wready_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;
  assign chan_pos      = pos_reg;
  assign irq           = irq_reg;

endmodule : dma_channel_flags

// ### verification/dma_channel_flags_monitor.sv
// port-level checks for the dma channel flag block
`timescale 1ns/1ns
module dma_channel_flags_monitor
  import dma_flags_pkg::*;
(
  input wire logic                     clk_sys,
  input wire logic                     reset_n,
  input wire logic                     s_axi_awvalid,
  input wire logic                     s_axi_awready,
  input wire logic                     s_axi_wvalid,
  input wire logic                     s_axi_wready,
  input wire logic [1:0]               s_axi_bresp,
  input wire logic                     s_axi_bvalid,
  input wire logic                     s_axi_bready,
  input wire logic                     s_axi_arvalid,
  input wire logic                     s_axi_arready,
  input wire logic [31:0]              s_axi_rdata,
  input wire logic                     s_axi_rvalid,
  input wire logic                     s_axi_rready,
  input wire dma_flags_pkg::chan_evt_s chan_evt,
  input wire dma_flags_pkg::chan_pos_s chan_pos
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  //----------------------------------------
  // bus and channel relations
  //----------------------------------------
  property p_wr_answer;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
  endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write answer late");
  property p_rd_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data moved");
  property p_wr_lock;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_wr_lock: assert property (p_wr_lock) else $error("write taken while answering");
  property p_rd_lock;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_rd_lock: assert property (p_rd_lock) else $error("read taken while answering");
  // busy lags the channel state by one cycle, hence the two-cycle window
  property p_err_stop;
    chan_pos.busy && (chan_evt.src_addr_err || chan_evt.dst_addr_err) |-> ##[1:2] !chan_pos.busy;
  endproperty
  a_err_stop: assert property (p_err_stop) else $error("no stop on address error");
  property p_match_stop;
    chan_pos.busy && chan_evt.pattern_match |-> ##[1:2] !chan_pos.busy;
  endproperty
  a_match_stop: assert property (p_match_stop) else $error("no stop on match");
  property p_ptr_step;
    $changed(chan_pos.dest_pointer) |->
      chan_pos.dest_pointer == $past(chan_pos.dest_pointer) + 16'h0001 || chan_pos.dest_pointer == 16'h0000;
  endproperty
  a_ptr_step: assert property (p_ptr_step) else $error("pointer jumped");
endmodule : dma_channel_flags_monitor

bind dma_channel_flags dma_channel_flags_monitor i_dma_channel_flags_monitor (.clk_sys, .reset_n,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .chan_evt, .chan_pos);

// ### verification/tb_top.sv
// self-checking bench for the dma channel flag block
`timescale 1ns/1ns
`include "dma_flags_params.svh"
module tb_top;
  import dma_flags_pkg::*;
  logic        clk_sys, reset_n, irq;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d, w;
  logic [3:0]  s_axi_wstrb;
  logic [2:0]  s_axi_awprot, s_axi_arprot;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [7:0]  irq_lines;
  logic [15:0] ds, cs, ss;
  chan_evt_s   chan_evt;
  chan_pos_s   chan_pos;
  int          fails, n_checks, seed, i, k, n;

  dma_channel_flags i_dma_channel_flags (.clk_sys, .reset_n, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .chan_evt, .irq_lines, .chan_pos, .irq);

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  //----------------------------------------
  // checking and bus tasks
  //----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error %0t: saw %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : results

  // each handshake is taken at the rising edge where ready is seen high
  task automatic axw(input logic [11:0] a, input logic [31:0] v, input logic [3:0] s);
    logic bh;
    @(posedge clk_sys);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= v;
    s_axi_wstrb   <= s;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    bh = 1'b0;
    while (!bh) begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      bh = s_axi_bvalid;
      r  = s_axi_bresp;
    end
    s_axi_bready <= 1'b0;
  endtask : axw

  task automatic axr(input logic [11:0] a);
    logic rh;
    @(posedge clk_sys);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    rh = 1'b0;
    while (!rh) begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      rh = s_axi_rvalid;
      d  = s_axi_rdata;
      r  = s_axi_rresp;
    end
    s_axi_rready <= 1'b0;
  endtask : axr

  task automatic bytes(input int cnt);
    repeat (cnt) begin
      @(posedge clk_sys);
      chan_evt.byte_moved <= 1'b1;
    end
    @(posedge clk_sys);
    chan_evt <= '0;
    repeat (3) @(posedge clk_sys);
  endtask : bytes

  task automatic ev(input logic [3:0] e, input logic [7:0] il);
    @(posedge clk_sys);
    chan_evt  <= e;
    irq_lines <= il;
    @(posedge clk_sys);
    chan_evt  <= '0;
    irq_lines <= '0;
    repeat (3) @(posedge clk_sys);
  endtask : ev

  task automatic cfg(input logic [15:0] dz, cz, sz, input logic [31:0] ctl);
    axw(`OFS_DEST_SIZE, {16'h0000, dz}, 4'hF);
    axw(`OFS_CELL_SIZE, {16'h0000, cz}, 4'hF);
    axw(`OFS_SOURCE_SIZE, {16'h0000, sz}, 4'hF);
    axw(`OFS_CHAN_CTRL, ctl, 4'hF);
    repeat (2) @(posedge clk_sys);
  endtask : cfg

  function automatic logic [31:0] exp_flags(input logic [15:0] dz, cz, sz, input int cnt);
    logic [15:0] p, c, t, m;
    logic [31:0] f;
    p = 16'h0000;
    c = 16'h0000;
    t = 16'h0000;
    f = 32'h0000_0000;
    m = (sz > dz) ? sz : dz;
    for (int j = 0; j < cnt && !f[3]; j++) begin
      p++;
      c++;
      t++;
      if (p == (dz >> 1)) f[4] = 1'b1;
      if (p == dz) begin
        f[5] = 1'b1;
        p = 16'h0000;
      end
      if (c == cz) begin
        f[2] = 1'b1;
        c = 16'h0000;
      end
      if (t == m) f[3] = 1'b1;
    end
    return f;
  endfunction : exp_flags
  //----------------------------------------
  // main sequence
  //----------------------------------------
  initial begin
    #400000;
    fails++;
    results();
  end

  initial begin
    seed = 6977;
    {fails, n_checks} = '0;
    {reset_n, s_axi_awaddr, s_axi_awprot, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_araddr, s_axi_arprot, s_axi_arvalid, s_axi_rready, chan_evt, irq_lines} = '0;
    repeat (16) @(posedge clk_sys);
    reset_n <= 1'b1;
    for (k = 0; k < 8; k++) begin
      axr(12'(k * 16));
      chk(d, 32'h0000_0000);
    end
    axr(12'h0FC);
    chk({30'h0, r}, {30'h0, `RESP_SLVERR});
    axw(12'h0FC, 32'hFFFF_FFFF, 4'hF);
    chk({30'h0, r}, {30'h0, `RESP_SLVERR});
    for (i = 0; i < 4; i++) begin
      w = $random(seed);
      axw(`OFS_SRC_START, w, 4'hF);
      axr(`OFS_SRC_START);
      chk(d, w);
    end
    axw(`OFS_SRC_START, 32'h0000_0000, 4'hF);
    axw(`OFS_SRC_START, 32'hFFFF_FFFF, 4'h2);
    chk({30'h0, r}, {30'h0, `RESP_OKAY});
    axr(`OFS_SRC_START);
    chk(d, 32'h0000_FF00);
    chk({30'h0, r}, {30'h0, `RESP_OKAY});
    axw(`OFS_DEST_POINTER, 32'h0000_00A5, 4'hF);
    axr(`OFS_DEST_POINTER);
    chk(d, 32'h0000_0000);
    ev(4'b1111, 8'hFF);
    axr(`OFS_EVENT_FLAGS);
    chk(d, 32'h0000_0000);
    axw(`OFS_IRQ_MASK, 32'h0000_003F, 4'hF);
    cfg(16'h0004, 16'h0002, 16'h0004, 32'h0000_0001);
    bytes(2);
    chk({31'h0, irq}, 32'h1);
    chk(chan_pos.source_addr, 32'h0000_FF02);
    chk({16'h0, chan_pos.dest_pointer}, 32'h0000_0002);
    axr(`OFS_DEST_POINTER);
    chk(d, 32'h0000_0002);
    axr(`OFS_EVENT_FLAGS);
    chk(d, 32'h0000_0014);
    bytes(2);
    axr(`OFS_EVENT_FLAGS);
    chk(d, 32'h0000_002C);
    axr(`OFS_EVENT_FLAGS);
    chk(d, 32'h0000_0000);
    repeat (2) @(posedge clk_sys);
    chk({31'h0, irq}, 32'h0);
    for (i = 0; i < 6; i++) begin
      ds = 16'(($random(seed) & 7) + 1);
      cs = 16'(($random(seed) & 3) + 1);
      ss = 16'(($random(seed) & 7) + 1);
      n = (ss > ds) ? ss : ds;
      cfg(ds, cs, ss, 32'h0000_0001);
      bytes(n + 1);
      axr(`OFS_EVENT_FLAGS);
      chk(d, exp_flags(ds, cs, ss, n + 1));
    end
    axw(`OFS_IRQ_MASK, 32'h0000_0000, 4'hF);
    cfg(16'h0008, 16'h0000, 16'h0008, 32'h0000_0001);
    ev(4'b0100, 8'h00);
    chk({31'h0, chan_pos.busy}, 32'h0);
    chk({31'h0, irq}, 32'h0);
    axw(`OFS_IRQ_MASK, 32'h0000_0008, 4'hF);
    repeat (2) @(posedge clk_sys);
    chk({31'h0, irq}, 32'h1);
    axr(`OFS_EVENT_FLAGS);
    chk(d, 32'h0000_0008);
    for (i = 0; i < 2; i++) begin
      cfg(16'h0008, 16'h0000, 16'h0008, 32'h0000_0001);
      ev(i ? 4'b0010 : 4'b0001, 8'h00);
      axr(`OFS_EVENT_FLAGS);
      chk(d, 32'h0000_0001);
    end
    for (i = 0; i < 4; i++) begin
      k = $random(seed) & 7;
      cfg(16'h0008, 16'h0000, 16'h0008, 32'h0000_0003 | (32'(k) << 8));
      ev(4'b0000, ~(8'h01 << k));
      chk({31'h0, chan_pos.busy}, 32'h1);
      ev(4'b1000, 8'h01 << k);
      chk({31'h0, chan_pos.busy}, 32'h0);
      axr(`OFS_EVENT_FLAGS);
      chk(d, 32'h0000_0002);
    end
    results();
  end
endmodule : tb_top
